// File: design/lss_sequencer.sv
// led strobe switch sequencer: power sequencing, strobe decoding, axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module lss_sequencer
   import lss_pkg::*;
#(
   parameter int unsigned OFFS_DELAY = OFFS_CYCLES,
   parameter int unsigned RAIL_DELAY = RAIL_CYCLES
)(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          projector_power_request,
   input  wire logic [1:0]    color_select,
   input  wire logic          rail_fault,
   output var  lss_rails_type rails,
   output var  lss_led_type   led,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
   logic [2:0]  control_ff;
   logic [9:0]  code_ff [3];
   logic [7:0]  dead_ff;
   logic [5:0]  limit_ff;
   lss_pwr_type pwr_ff;
   lss_pwr_type nxt_pwr;
   logic [31:0] tmr_ff;
   logic        req_d_ff;
   logic        fault_latch_ff;
   logic [5:0]  sw_ff;
   logic [5:0]  target;
   logic [7:0]  dead_cnt_ff;
   logic        trans_ff;
   logic [1:0]  sel_ff;
   logic        active;

////////////////////////////////////////////////////////////////////////////////
// register bus
   logic [7:0]  aw_addr_ff;
   logic        aw_have_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        w_have_ff;
   logic        do_write;
   logic        wr_hit;
   logic        rd_hit;
   logic [31:0] rd_val;

   assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

   always_comb
   begin
      wr_hit = 1'b1;
      unique case (aw_addr_ff)
         ADDR_CONTROL, ADDR_CODE_FOUR, ADDR_CODE_FIVE, ADDR_CODE_SIX,
         ADDR_DEAD_TIME, ADDR_CUR_LIMIT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_ff    <= 1'b0;
         w_have_ff     <= 1'b0;
         aw_addr_ff    <= 8'h00;
         w_data_ff     <= 32'h0000_0000;
         w_strb_ff     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_have_ff && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_ff && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_ff    <= 1'b1;
            aw_addr_ff    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_ff    <= 1'b1;
            w_data_ff    <= s_axi_wdata;
            w_strb_ff    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_have_ff   <= 1'b0;
            w_have_ff    <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         control_ff <= CONTROL_RESET;
         dead_ff    <= DEAD_RESET;
         limit_ff   <= LIMIT_RESET;
      end
      else
      begin
         if (do_write && aw_addr_ff == ADDR_CONTROL && w_strb_ff[0])
            control_ff <= w_data_ff[2:0];
         if (do_write && aw_addr_ff == ADDR_DEAD_TIME && w_strb_ff[0])
            dead_ff <= w_data_ff[7:0];
         if (do_write && aw_addr_ff == ADDR_CUR_LIMIT && w_strb_ff[0])
            limit_ff <= w_data_ff[5:0];
         // fault clear wins over a software write in the same cycle
         if (rail_fault && pwr_ff != PWR_OFF)
            control_ff[CTL_MIRROR_BIT] <= 1'b0;
      end
   end

   // per-color 10-bit current codes
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_code
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               code_ff[gi] <= CODE_RESET;
            else if (do_write && aw_addr_ff == ADDR_CODE_FOUR + 8'(4 * gi))
            begin
               if (w_strb_ff[0])
                  code_ff[gi][7:0] <= w_data_ff[7:0];
               if (w_strb_ff[1])
                  code_ff[gi][9:8] <= w_data_ff[9:8];
            end
         end
      end
   endgenerate

   always_comb
   begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr)
         ADDR_CONTROL:   rd_val = {29'h0, control_ff};
         ADDR_CODE_FOUR: rd_val = {22'h0, code_ff[0]};
         ADDR_CODE_FIVE: rd_val = {22'h0, code_ff[1]};
         ADDR_CODE_SIX:  rd_val = {22'h0, code_ff[2]};
         ADDR_DEAD_TIME: rd_val = {24'h0, dead_ff};
         ADDR_CUR_LIMIT: rd_val = {26'h0, limit_ff};
         ADDR_STATUS:    rd_val = {18'h0, fault_latch_ff, trans_ff, sw_ff, 1'b0, pwr_ff};
         default:        rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= AXI_OKAY;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else
         s_axi_arready <= 1'b1;
   end

////////////////////////////////////////////////////////////////////////////////
// power sequencing
   always_comb
   begin
      nxt_pwr = pwr_ff;
      unique case (pwr_ff)
         PWR_OFF:
            if (projector_power_request && !req_d_ff && control_ff[CTL_MIRROR_BIT]
                && !fault_latch_ff)
               nxt_pwr = PWR_WOFS;
         PWR_WOFS:
            if (!projector_power_request || rail_fault)
               nxt_pwr = PWR_OFF;
            else if (tmr_ff >= OFFS_DELAY - 1)
               nxt_pwr = PWR_WRAIL;
         PWR_WRAIL:
            if (!projector_power_request || rail_fault)
               nxt_pwr = PWR_OFF;
            else if (tmr_ff >= RAIL_DELAY - 1)
               nxt_pwr = PWR_ACT;
         PWR_ACT:
            if (rail_fault)
               nxt_pwr = PWR_OFF;
            else if (!projector_power_request || !control_ff[CTL_MIRROR_BIT])
               nxt_pwr = PWR_LDOWN;
         PWR_LDOWN:
            if (rail_fault || tmr_ff >= LED_OFF_CYCLES)
               nxt_pwr = PWR_OFF;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwr_ff         <= PWR_OFF;
         tmr_ff         <= 32'h0000_0000;
         req_d_ff       <= 1'b0;
         fault_latch_ff <= 1'b0;
      end
      else
      begin
         pwr_ff   <= nxt_pwr;
         req_d_ff <= projector_power_request;
         tmr_ff   <= (nxt_pwr != pwr_ff) ? 32'h0000_0000 : tmr_ff + 32'h0000_0001;
         // restart needs a request toggle after a fault
         if (rail_fault && pwr_ff != PWR_OFF)
            fault_latch_ff <= 1'b1;
         else if (!projector_power_request)
            fault_latch_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rails <= '0;
      else
      begin
         rails.offset_rail <= (nxt_pwr != PWR_OFF) && (nxt_pwr != PWR_WOFS);
         rails.bias_rail   <= (nxt_pwr == PWR_ACT) || (nxt_pwr == PWR_LDOWN);
         rails.reset_rail  <= (nxt_pwr == PWR_ACT) || (nxt_pwr == PWR_LDOWN);
      end
   end

////////////////////////////////////////////////////////////////////////////////
// strobe decoding with break-before-make
   assign active = (pwr_ff == PWR_ACT) && control_ff[CTL_LEDSUP_BIT];

   always_comb
   begin
      target = 6'h00;
      if (active)
      begin
         if (!control_ff[CTL_TOPO_BIT])
         begin
            unique case (color_select)
               2'h0: target = 6'b000111;
               2'h1: target = 6'b001111;
               2'h2: target = 6'b010111;
               2'h3: target = 6'b100111;
            endcase
         end
         else
         begin
            unique case (color_select)
               2'h0: target = 6'b000000;
               2'h1: target = 6'b100001;
               2'h2: target = 6'b011100;
               2'h3: target = 6'b011010;
            endcase
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sw_ff       <= 6'h00;
         dead_cnt_ff <= 8'h00;
         trans_ff    <= 1'b0;
         sel_ff      <= 2'h0;
      end
      else if ((sw_ff & ~target) != 6'h00)
      begin
         sw_ff       <= sw_ff & target;
         dead_cnt_ff <= dead_ff;
         trans_ff    <= 1'b1;
      end
      else if (dead_cnt_ff != 8'h00)
         dead_cnt_ff <= dead_cnt_ff - 8'h01;
      else
      begin
         sw_ff    <= target;
         trans_ff <= (sw_ff != target);
         sel_ff   <= active ? color_select : 2'h0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         led <= '0;
      else
      begin
         led.driver_en     <= active;
         led.switches      <= active ? sw_ff : 6'h00;
         led.current_code  <= (active && sel_ff != 2'h0) ? code_ff[sel_ff - 2'h1]
                                                        : 10'h000;
         led.limit_level   <= limit_ff[LIM_LEVEL_LSB +: 3];
         led.limit_enable  <= trans_ff ? limit_ff[LIM_EN_LSB +: 3] : 3'h0;
         led.in_transition <= trans_ff;
      end
   end

endmodule
`default_nettype wire

// File: design/lss_pkg.sv
// package of constants and carrier types for the led strobe switch sequencer
// Notes on behaviour
// - power request high: offset rail after 100 ms, bias and reset rails 10 ms later.
// - led driver and strobe decoder stay off until all three rails are enabled.
// - a fault on any one mirror rail disables all three rails together.
// - both supply enables reset to one, so rising request runs through both rail waits to active.
// - strobe decoder drives six switch gates from color select and topology bit.
// - topology bit one is cathode-cathode-anode, zero is common anode, the default.
// - common anode: switches one to three closed; codes 1-3 close four, five, six.
// - cathode mapping: 0 all open, 1 six+one, 2 five+four+three, 3 five+four+two.
// - selected color routes its own 10-bit current code; code 0 selects none.
// - a color change that opens switches opens them first, waits dead time, then closes new ones.
// - switches closed in both settings stay closed through the dead time.
// - each current code is 10 bits, linear, 0x100 near 272 mA.
// - current-limit register: three-bit level plus three per-switch enable bits.
package lss_pkg;
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned OFS_DELAY_MS    = 100;
   localparam int unsigned RAIL_DELAY_MS   = 10;
   localparam int unsigned OFFS_CYCLES     = CLK_HZ / 1000 * OFS_DELAY_MS;
   localparam int unsigned RAIL_CYCLES     = CLK_HZ / 1000 * RAIL_DELAY_MS;
   localparam int unsigned LED_OFF_CYCLES  = 1;
   // register byte addresses
   localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
   localparam logic [7:0]  ADDR_CODE_FOUR  = 8'h04;
   localparam logic [7:0]  ADDR_CODE_FIVE  = 8'h08;
   localparam logic [7:0]  ADDR_CODE_SIX   = 8'h0C;
   localparam logic [7:0]  ADDR_DEAD_TIME  = 8'h10;
   localparam logic [7:0]  ADDR_CUR_LIMIT  = 8'h14;
   localparam logic [7:0]  ADDR_STATUS     = 8'h18;
   // control fields
   localparam int unsigned CTL_MIRROR_BIT  = 0;
   localparam int unsigned CTL_LEDSUP_BIT  = 1;
   localparam int unsigned CTL_TOPO_BIT    = 2;
   localparam logic [2:0]  CONTROL_RESET   = 3'h3;
   localparam logic [9:0]  CODE_RESET      = 10'h000;
   localparam logic [7:0]  DEAD_RESET      = 8'h04;
   localparam logic [5:0]  LIMIT_RESET     = 6'h00;
   localparam int unsigned LIM_LEVEL_LSB   = 0;
   localparam int unsigned LIM_EN_LSB      = 3;
   localparam logic [1:0]  AXI_OKAY        = 2'h0;
   localparam logic [1:0]  AXI_SLVERR      = 2'h2;

   typedef enum logic [4:0] {
      PWR_OFF   = 5'h01,
      PWR_WOFS  = 5'h02,
      PWR_WRAIL = 5'h04,
      PWR_ACT   = 5'h08,
      PWR_LDOWN = 5'h10
   } lss_pwr_type;

   typedef struct packed {
      logic offset_rail;
      logic bias_rail;
      logic reset_rail;
   } lss_rails_type;

   typedef struct packed {
      logic       driver_en;
      logic [5:0] switches;
      logic [9:0] current_code;
      logic [2:0] limit_level;
      logic [2:0] limit_enable;
      logic       in_transition;
   } lss_led_type;
endpackage

// File: tb/lss_ctrl_model.sv
// display controller model driving power request and color select
`timescale 1ns/1ps
`default_nettype none
module lss_ctrl_model
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       want_power,
   input  wire logic [1:0] want_color,
   output logic            projector_power_request,
   output logic [1:0]      color_select
);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         projector_power_request <= 1'b0;
         color_select            <= 2'h0;
      end
      else
      begin
         projector_power_request <= want_power;
         color_select            <= want_color;
      end
   end
endmodule
`default_nettype wire

// File: tb/lss_sequencer_chk.sv
// port checker for the led strobe switch sequencer
`timescale 1ns/1ps
`default_nettype none
module lss_sequencer_chk
   import lss_pkg::*;
#(
   parameter int unsigned OFFS_DELAY = OFFS_CYCLES,
   parameter int unsigned RAIL_DELAY = RAIL_CYCLES
)(
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          projector_power_request,
   input wire logic          rail_fault,
   input wire lss_rails_type rails,
   input wire lss_led_type   led
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic [5:0] sw = led.switches;
   AST_RAIL_SET: assert property (rails inside {3'h0, 3'h4, 3'h7})
      else $error("illegal rail combination");
   AST_OFS_WAIT: assert property ($rose(rails.offset_rail) |-> $past(projector_power_request, OFFS_DELAY))
      else $error("offset rail early");
   AST_BIAS_WAIT: assert property ($rose(rails.bias_rail) |-> $past(rails.offset_rail, RAIL_DELAY))
      else $error("bias rail early");
   AST_LED_GATE: assert property ((led.driver_en || sw != 6'h00) && !$past(rail_fault) |-> &rails)
      else $error("led active without rails");
   AST_FAULT_ALL: assert property (rail_fault && rails != 3'h0 |=> rails == 3'h0)
      else $error("rails kept after fault");
   AST_LED_FIRST: assert property ($fell(rails.offset_rail) && !$past(rail_fault) |->
      $past(led.driver_en) == 1'b0 && $past(sw) == 6'h00)
      else $error("rails off before led");
   AST_MAP_LEGAL: assert property (led.driver_en && !led.in_transition |->
      sw inside {6'h07, 6'h0F, 6'h17, 6'h27, 6'h00, 6'h21, 6'h1C, 6'h1A})
      else $error("switch pattern not in map");
   AST_BBM: assert property ((sw & ~$past(sw)) != 6'h00 |->
      ($past(sw) & ~sw) == 6'h00 && $past(sw) == $past(sw, 2))
      else $error("close without dead time");
   AST_CODE_NONE: assert property (led.driver_en && !led.in_transition && sw[5:3] == 3'h0 |->
      led.current_code == 10'h000)
      else $error("current code without color");
   cover property (&rails);
   cover property (led.in_transition);
   cover property (rail_fault && rails != 3'h0);
endmodule
bind lss_sequencer lss_sequencer_chk #(.OFFS_DELAY(OFFS_DELAY), .RAIL_DELAY(RAIL_DELAY)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .projector_power_request(projector_power_request),
   .rail_fault(rail_fault), .rails(rails), .led(led));
`default_nettype wire

// File: tb/tb_top.sv
// self-checking testbench for the led strobe switch sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import lss_pkg::*;
();
   localparam int unsigned OFS = 20;
   localparam int unsigned RL  = 5;
   localparam logic [5:0] MAP [8] = '{6'h07, 6'h0F, 6'h17, 6'h27, 6'h00, 6'h21, 6'h1C, 6'h1A};
   logic aclk = 1'b0, aresetn = 1'b0, want_power = 1'b0, rail_fault = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic projector_power_request, awready, wready, bvalid, arready, rvalid, held;
   logic [1:0] want_color = 2'h0, color_select, bresp, rresp;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [9:0] code [4];
   logic [33:0] exp_q [$];
   lss_rails_type rails;
   lss_led_type led;
   int n_mismatch = 0, check_count = 0, cyc = 0, seed = 16, n, g, t;
   lss_ctrl_model ctl_u (.aclk(aclk), .aresetn(aresetn), .want_power(want_power),
      .want_color(want_color), .projector_power_request(projector_power_request),
      .color_select(color_select));
   lss_sequencer #(.OFFS_DELAY(OFS), .RAIL_DELAY(RL)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .projector_power_request(projector_power_request), .color_select(color_select),
      .rail_fault(rail_fault), .rails(rails), .led(led), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      exp_q.push_back({32'h0, er});
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && cyc < 30000);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      exp_q.push_back({d, er});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && cyc < 30000);
      rready <= 1'b0;
   endtask
   task automatic wait_rails(input logic [2:0] r);
      n = 0;
      while (rails !== r && n < 100)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic power_up;
      want_power <= 1'b1;
      wait_rails(3'h4);
      cmp(34'(n >= OFS + 1 && n <= OFS + 4), 34'h1);
      cmp(34'(led.driver_en), 34'h0);
      wait_rails(3'h7);
      cmp(34'(n), 34'(RL));
      repeat (4) @(posedge aclk);
      cmp(34'(led.driver_en), 34'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always #2.5 aclk = ~aclk;
   always @(posedge aclk)
      if (bvalid === 1'b1 && bready === 1'b1)
         cmp({32'h0, bresp}, exp_q.pop_front());
      else if (rvalid === 1'b1 && rready === 1'b1)
         cmp({rdata, rresp}, exp_q.pop_front());
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(ADDR_CONTROL, {29'h0, CONTROL_RESET}, AXI_OKAY);
      axi_rd(ADDR_DEAD_TIME, {24'h0, DEAD_RESET}, AXI_OKAY);
      axi_rd(ADDR_CUR_LIMIT, 32'h0, AXI_OKAY);
      axi_rd(8'h1C, 32'h0, AXI_SLVERR);
      axi_wr(8'h1C, 32'h5, AXI_SLVERR);
      code[0] = 10'h000;
      for (int i = 1; i < 4; i++)
      begin
         code[i] = 10'($random(seed));
         axi_wr(ADDR_CODE_FOUR + 8'(4 * i - 4), {22'h0, code[i]}, AXI_OKAY);
         axi_rd(ADDR_CODE_FOUR + 8'(4 * i - 4), {22'h0, code[i]}, AXI_OKAY);
      end
      axi_wr(ADDR_CUR_LIMIT, 32'h0000000D, AXI_OKAY);
      axi_rd(ADDR_CUR_LIMIT, 32'h0000000D, AXI_OKAY);
      $display("test registers done");
      power_up();
      for (int i = 0; i < 8; i++)
      begin
         axi_wr(ADDR_CONTROL, 32'(3 + 4 * (i / 4)), AXI_OKAY);
         want_color <= 2'(i);
         repeat (20) @(posedge aclk);
         cmp(34'(led.switches), 34'(MAP[i]));
         cmp(34'(led.current_code), 34'(code[i % 4]));
      end
      $display("test strobe map done");
      axi_wr(ADDR_DEAD_TIME, 32'h8, AXI_OKAY);
      want_color <= 2'h2;
      g = 0;
      t = 0;
      held = 1'b1;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge aclk);
         if (led.switches === 6'h18)
            g++;
         if (led.in_transition === 1'b1 && led.limit_enable === 3'h1)
            t++;
         if (led.switches[4:3] !== 2'h3)
            held = 1'b0;
      end
      cmp(34'(g), 34'h9);
      cmp(34'(held), 34'h1);
      cmp(34'(t > 8), 34'h1);
      cmp(34'({led.limit_level, led.limit_enable}), 34'h28);
      $display("test dead time done");
      want_power <= 1'b0;
      n = 0;
      while (led.driver_en !== 1'b0 && n < 100)
      begin
         @(posedge aclk);
         n++;
      end
      cmp(34'(rails), 34'h7);
      wait_rails(3'h0);
      cmp(34'({rails, led.driver_en, led.switches}), 34'h0);
      power_up();
      rail_fault <= 1'b1;
      repeat (2) @(posedge aclk);
      cmp(34'(rails), 34'h0);
      rail_fault <= 1'b0;
      axi_rd(ADDR_CONTROL, 32'h6, AXI_OKAY);
      axi_wr(ADDR_CONTROL, 32'h7, AXI_OKAY);
      repeat (40) @(posedge aclk);
      cmp(34'(rails), 34'h0);
      $display("test power down and fault done");
      complete_run();
   end
endmodule
`default_nettype wire
